// [src/lsfd_pkg.sv]
// Overview of operation
// - short to supply is checked only while the output is commanded off
// - short fault latches only after the gate drive has discharged
// - short sets short and off-open flags; fault pin shows it live
// - status read clears short flag only once the short has gone
// - short_detect_disable stops short detection and report per output
// - off output pulled above openload threshold flags an openload
// - off-open flag clears on read only when gone and fault pin high
// - off_open_detect_disable stops off-state openload check per output
// - led_open_select picks led threshold, otherwise bulb threshold
// - on-state openload sets flag, output stays on, fault pin untouched
// - led openload sampled once per check period at full duty only
// - on-open flag clears only after removal and a status read
// - on_open_detect_disable stops on-state openload check per output
// - sense pin routes scaled current or ground-flag temperature
// - current sense only while selected switch on, never in fail-safe
// - normal mode latches temperature prewarning, cleared by read or power-on reset
// - supply clamp during overload turn-off switches every output on
// - logic supply loss with fail enable resets serial registers
// - without logic supply outputs follow direct inputs, zero config
// - power loss with logic supply keeps config, reports supply low
// - both supplies below power-on threshold clear registers and faults
package lsfd_pkg;

   localparam int        NCH           = 2;
   localparam int        CLK_MHZ       = 25;
   // led check period in microseconds, plain default
   localparam int        LED_CHECK_US  = 1000;
   localparam int        LED_CHECK_CYC = LED_CHECK_US * CLK_MHZ;
   localparam logic [7:0] DUTY_FULL    = 8'hff;
   localparam logic      FLAG_RST      = 1'b0;
   localparam logic      FAULT_N_RST   = 1'b1;
   localparam logic      SWITCH_RST    = 1'b0;

   // per-output configuration from the serial registers
   typedef struct packed {
      logic short_detect_disable;
      logic off_open_detect_disable;
      logic on_open_detect_disable;
      logic led_open_select;
      logic sense_ratio_select;
   } lsfd_ch_cfg_t;

   // global configuration from global_config_reg
   typedef struct packed {
      logic       logic_supply_fail_enable;
      logic       pwm_module_enable;
      logic       temp_feedback_enable;
      logic       sense_output_enable;
      logic [1:0] sense_route_select;
   } lsfd_glb_cfg_t;

   // per-output analog comparator and pin levels
   typedef struct packed {
      logic gate_low;
      logic above_short_thr;
      logic above_open_thr;
      logic below_bulb_thr;
      logic below_led_thr;
      logic direct_in;
   } lsfd_ch_sense_t;

   // supply monitors
   typedef struct packed {
      logic logic_supply_ok;
      logic power_supply_ok;
      logic supply_above_por;
      logic clamp_exceeded;
      logic temp_warn;
   } lsfd_supply_t;

   typedef struct packed {
      logic short_to_supply_flag;
      logic off_open_flag;
      logic on_open_flag;
   } lsfd_ch_flags_t;

   typedef enum logic [1:0] {SENSE_OFF, SENSE_CURRENT, SENSE_TEMP} lsfd_sense_t;

endpackage

// [src/lsfd_diag.sv]
`timescale 1ns/1ps
module lsfd_diag
   import lsfd_pkg::*;
#(
   parameter int LED_CHECK_CYCLES = LED_CHECK_CYC
) (
   input  wire logic                       i_core_clk,
   input  wire logic                       i_rst_n,
   input  wire lsfd_ch_sense_t [NCH-1:0]   i_ch_sense,
   input  wire lsfd_supply_t               i_supply,
   input  wire lsfd_ch_cfg_t   [NCH-1:0]   i_ch_cfg,
   input  wire lsfd_glb_cfg_t              i_glb_cfg,
   input  wire logic           [NCH-1:0]   i_out_cmd,
   input  wire logic [NCH-1:0][7:0]        i_duty,
   input  wire logic           [NCH-1:0]   i_overload_off,
   input  wire logic                       i_status_read,
   output lsfd_ch_flags_t      [NCH-1:0]   o_ch_flags,
   output logic                            o_fault_status_n,
   output logic                            o_temp_prewarn_flag,
   output logic                            o_supply_low_flag,
   output logic                [NCH-1:0]   o_switch_on,
   output lsfd_sense_t                     o_sense_mode,
   output logic                            o_sense_channel,
   output logic                            o_sense_ratio,
   output logic                            o_fail_safe,
   output logic                            o_serial_clear
);

   localparam int CW = $clog2(LED_CHECK_CYCLES + 1);
   localparam int SW = $bits(lsfd_ch_sense_t) * NCH + $bits(lsfd_supply_t);

   // ------------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------------
   // first stage feeds only the second stage
   logic [SW-1:0]              meta_reg;
   logic [SW-1:0]              sync_reg;
   lsfd_ch_sense_t [NCH-1:0]   chs;
   lsfd_supply_t               sup;

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= {i_ch_sense, i_supply};
         sync_reg <= meta_reg;
      end
   end

   assign {chs, sup} = sync_reg;

   // ------------------------------------------------------------------
   // mode and effective configuration
   // ------------------------------------------------------------------
   logic                     fail_safe;
   logic                     por;
   lsfd_ch_cfg_t [NCH-1:0]   cfg;
   lsfd_glb_cfg_t            gcfg;
   logic         [NCH-1:0]   cmd_on;

   assign fail_safe = !sup.logic_supply_ok;
   assign por       = !sup.supply_above_por;

   // without logic supply every setting except logic_supply_fail_enable reads as zero
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         cfg[c]    = fail_safe ? '0 : i_ch_cfg[c];
         cmd_on[c] = fail_safe ? chs[c].direct_in : i_out_cmd[c];
      end
      gcfg = fail_safe ? '0 : i_glb_cfg;
   end

   // ------------------------------------------------------------------
   // led openload period timers
   // ------------------------------------------------------------------
   logic [NCH-1:0][CW-1:0] led_cnt_reg;
   logic [NCH-1:0][CW-1:0] led_cnt_next;
   logic [NCH-1:0]         led_run;
   logic [NCH-1:0]         led_tick;

   // a timer only runs while the output is fully on in led mode
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         led_run[c]  = cmd_on[c] && cfg[c].led_open_select
                    && gcfg.pwm_module_enable && i_duty[c] == DUTY_FULL;
         led_tick[c] = led_run[c]
                    && led_cnt_reg[c] == CW'(LED_CHECK_CYCLES - 1);
         if (!led_run[c] || led_tick[c]) begin
            led_cnt_next[c] = '0;
         end else begin
            led_cnt_next[c] = led_cnt_reg[c] + CW'(1);
         end
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         led_cnt_reg <= '0;
      end else begin
         led_cnt_reg <= led_cnt_next;
      end
   end

   // ------------------------------------------------------------------
   // fault detection and latched flags
   // ------------------------------------------------------------------
   lsfd_ch_flags_t [NCH-1:0] flags_reg;
   lsfd_ch_flags_t [NCH-1:0] flags_next;
   logic                     fault_n_reg;
   logic                     fault_n_next;
   logic                     prewarn_reg;
   logic                     prewarn_next;
   logic                     uv_reg;
   logic                     uv_next;
   logic [NCH-1:0]           short_cond;
   logic [NCH-1:0]           open_cond;
   logic [NCH-1:0]           on_present;
   logic [NCH-1:0]           on_set;
   logic                     uv_cond;

   // set always wins over a read clear in the same cycle
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         short_cond[c] = !cmd_on[c] && chs[c].gate_low
                      && chs[c].above_short_thr
                      && !cfg[c].short_detect_disable;
         open_cond[c]  = !cmd_on[c] && chs[c].gate_low
                      && chs[c].above_open_thr
                      && !cfg[c].off_open_detect_disable;
         on_present[c] = cmd_on[c] && !cfg[c].on_open_detect_disable
                      && (cfg[c].led_open_select ? chs[c].below_led_thr
                                                 : chs[c].below_bulb_thr);
         on_set[c]     = on_present[c]
                      && (!cfg[c].led_open_select || led_tick[c]);
         flags_next[c].short_to_supply_flag = short_cond[c]
            || (flags_reg[c].short_to_supply_flag
                && !i_status_read);
         flags_next[c].off_open_flag = short_cond[c] || open_cond[c]
            || (flags_reg[c].off_open_flag
                && !(i_status_read && fault_n_reg));
         flags_next[c].on_open_flag = on_set[c]
            || (flags_reg[c].on_open_flag
                && !(i_status_read && !on_present[c]));
         if (por) begin
            flags_next[c] = '0;
         end
      end
      // on-state openload never pulls the fault pin
      fault_n_next = !(|short_cond || |open_cond);
      uv_cond      = !sup.power_supply_ok && sup.logic_supply_ok;
      uv_next      = !por && (uv_cond || (uv_reg && !i_status_read));
      prewarn_next = !por && ((sup.temp_warn && !fail_safe)
                     || (prewarn_reg && !i_status_read));
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         flags_reg   <= '0;
         fault_n_reg <= FAULT_N_RST;
         prewarn_reg <= FLAG_RST;
         uv_reg      <= FLAG_RST;
      end else begin
         flags_reg   <= flags_next;
         fault_n_reg <= fault_n_next;
         prewarn_reg <= prewarn_next;
         uv_reg      <= uv_next;
      end
   end

   // ------------------------------------------------------------------
   // output switches, sense routing and serial register clear
   // ------------------------------------------------------------------
   logic [NCH-1:0] sw_reg;
   logic [NCH-1:0] sw_next;
   lsfd_sense_t    sense_reg;
   lsfd_sense_t    sense_next;
   logic           sch_reg;
   logic           sch_next;
   logic           sratio_reg;
   logic           sratio_next;
   logic           fs_reg;
   logic           clr_reg;
   logic           clr_next;
   logic           clamp;

   // a clamp overrides the overload turn-off on every output
   always_comb begin
      clamp    = sup.clamp_exceeded && |i_overload_off;
      sw_next  = clamp ? '1 : cmd_on;
      sch_next = gcfg.sense_route_select[0];
      sratio_next = cfg[sch_next].sense_ratio_select;
      if (gcfg.temp_feedback_enable) begin
         sense_next = SENSE_TEMP;
      end else if (gcfg.sense_output_enable && !fail_safe
                   && !gcfg.sense_route_select[1] && sw_next[sch_next]) begin
         sense_next = SENSE_CURRENT;
      end else begin
         sense_next = SENSE_OFF;
      end
      clr_next = por || (fail_safe
                 && i_glb_cfg.logic_supply_fail_enable);
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sw_reg     <= {NCH{SWITCH_RST}};
         sense_reg  <= SENSE_OFF;
         sch_reg    <= 1'b0;
         sratio_reg <= 1'b0;
         fs_reg     <= 1'b0;
         clr_reg    <= 1'b0;
      end else begin
         sw_reg     <= sw_next;
         sense_reg  <= sense_next;
         sch_reg    <= sch_next;
         sratio_reg <= sratio_next;
         fs_reg     <= fail_safe;
         clr_reg    <= clr_next;
      end
   end

   assign o_ch_flags          = flags_reg;
   assign o_fault_status_n    = fault_n_reg;
   assign o_temp_prewarn_flag = prewarn_reg;
   assign o_supply_low_flag   = uv_reg;
   assign o_switch_on         = sw_reg;
   assign o_sense_mode        = sense_reg;
   assign o_sense_channel     = sch_reg;
   assign o_sense_ratio       = sratio_reg;
   assign o_fail_safe         = fs_reg;
   assign o_serial_clear      = clr_reg;

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_short0;
      short_cond[0] && !por;
   endsequence
   sequence s_read_gone0;
      i_status_read && !short_cond[0] && !por;
   endsequence

   a_short_latch: assert property (s_short0 |=>
      flags_reg[0].short_to_supply_flag && flags_reg[0].off_open_flag
      && !fault_n_reg) else $error("short not latched on output 0");
   a_short_clear: assert property (s_read_gone0 ##0 !open_cond[0]
      |=> !flags_reg[0].short_to_supply_flag)
      else $error("short flag kept after read");
   a_short_off_only: assert property (
      $rose(flags_reg[1].short_to_supply_flag)
      |-> $past(!cmd_on[1] && chs[1].gate_low))
      else $error("short latched while output driven");
   a_short_disable: assert property (
      i_ch_cfg[1].short_detect_disable && !fail_safe |-> !short_cond[1])
      else $error("disabled short seen");
   a_off_open_hold: assert property (flags_reg[0].off_open_flag
      && !fault_n_reg && !por |=> flags_reg[0].off_open_flag)
      else $error("off-open cleared with fault pin low");
   a_on_open_pin: assert property (on_set[1] && !short_cond[1]
      && !open_cond[1] && !short_cond[0] && !open_cond[0]
      |=> fault_n_reg && sw_reg[1]) else $error("on-open disturbed pin");
   a_led_period: assert property ($rose(flags_reg[0].on_open_flag)
      && $past(cfg[0].led_open_select) |-> $past(led_tick[0]))
      else $error("led openload off period");
   a_clamp_on: assert property (
      sup.clamp_exceeded && |i_overload_off |=> &sw_reg ##1 1)
      else $error("clamp did not switch all on");
   a_sense_fs: assert property (fail_safe |=>
      sense_reg != SENSE_CURRENT) else $error("current sense in fail-safe");
   a_por_clear: assert property (por |=> flags_reg == '0
      && !prewarn_reg && clr_reg) else $error("power-on reset incomplete");
   a_prewarn_keep: assert property (prewarn_reg && !i_status_read
      && !por |=> prewarn_reg) else $error("prewarning lost without read");

   // openload guards on output 1, where most openload cases are driven
   a_open_set: assert property (open_cond[1] && !por
      |=> flags_reg[1].off_open_flag && !fault_n_reg)
      else $error("off-state openload not latched");
   a_open_disable: assert property (
      i_ch_cfg[1].off_open_detect_disable && !fail_safe |-> !open_cond[1])
      else $error("disabled openload seen");
   a_on_disable: assert property (
      i_ch_cfg[1].on_open_detect_disable && !fail_safe |-> !on_present[1])
      else $error("disabled on-state openload seen");
   a_bulb_set: assert property (
      on_present[1] && !cfg[1].led_open_select && !por
      |=> flags_reg[1].on_open_flag) else $error("bulb openload missed");
   a_on_open_keep: assert property (
      flags_reg[1].on_open_flag && on_present[1] && !por
      |=> flags_reg[1].on_open_flag) else $error("on-open cleared early");
   a_on_open_clear: assert property (
      i_status_read && !on_present[1] && !por
      |=> !flags_reg[1].on_open_flag) else $error("on-open kept after read");

   // mode handling: fail-safe, supply loss and sense routing
   a_fs_follow: assert property (
      fail_safe && chs[0].direct_in |=> sw_reg[0])
      else $error("fail-safe output ignored direct input");
   a_serial_clr: assert property (
      fail_safe && i_glb_cfg.logic_supply_fail_enable |=> clr_reg)
      else $error("serial registers not cleared");
   a_uv_set: assert property (uv_cond && !por |=> uv_reg)
      else $error("supply low not reported");
   a_sense_temp: assert property (
      gcfg.temp_feedback_enable |=> sense_reg == SENSE_TEMP)
      else $error("temperature not routed");
   a_sense_on: assert property (
      sense_reg == SENSE_CURRENT |-> sw_reg[sch_reg])
      else $error("current sense with switch off");

endmodule

// [verification/lsfd_mcu_model.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// controller model: global config and serial status reads
// ------------------------------------------------------------
module lsfd_mcu_model
   import lsfd_pkg::*;
(
   input  wire logic     i_core_clk,
   output lsfd_glb_cfg_t o_glb_cfg,
   output logic          o_status_read
);
   initial begin
      o_glb_cfg     = '0;
      o_status_read = 1'b0;
   end

   // one-cycle read pulse, launched just after an edge
   task automatic read_status();
      @(posedge i_core_clk);
      #1 o_status_read = 1'b1;
      @(posedge i_core_clk);
      #1 o_status_read = 1'b0;
   endtask

   // global config changes only off the sampling edge
   task automatic set_glb(input logic [5:0] v);
      @(posedge i_core_clk);
      #1 o_glb_cfg = v;
   endtask

   // led check needs pwm module on for at least one period
   task automatic hold_led(input int n);
      @(posedge i_core_clk);
      #1 o_glb_cfg.pwm_module_enable = 1'b1;
      repeat (n) @(posedge i_core_clk);
      #1;
   endtask
endmodule

// [verification/lsfd_diag_bench.sv]
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin \
   fails++; $display("[ERR] %s exp %h got %h", nm, exp, got); end end

module lsfd_diag_bench;
   import lsfd_pkg::*;
   localparam int LED_N = 8;
   logic                 clk;
   logic                 rst_n;
   lsfd_ch_sense_t [1:0] sense;
   lsfd_supply_t         supply;
   lsfd_ch_cfg_t   [1:0] cfg;
   lsfd_glb_cfg_t        glb;
   logic           [1:0] cmd;
   logic      [1:0][7:0] duty;
   logic           [1:0] ovl;
   logic                 rd;
   lsfd_ch_flags_t [1:0] flags;
   logic                 fault_n, prewarn, sup_low, fsafe, sclr;
   logic                 s_chan, s_ratio;
   logic           [1:0] sw;
   lsfd_sense_t          smode;
   int                   fails = 0;
   int                   compares = 0;

   always #20 clk = ~clk;

   lsfd_mcu_model mcu_i (.i_core_clk(clk), .o_glb_cfg(glb),
                         .o_status_read(rd));

   lsfd_diag #(.LED_CHECK_CYCLES(LED_N)) lsfd_diag_i (
      .i_core_clk(clk), .i_rst_n(rst_n), .i_ch_sense(sense),
      .i_supply(supply), .i_ch_cfg(cfg), .i_glb_cfg(glb),
      .i_out_cmd(cmd), .i_duty(duty), .i_overload_off(ovl),
      .i_status_read(rd), .o_ch_flags(flags),
      .o_fault_status_n(fault_n), .o_temp_prewarn_flag(prewarn),
      .o_supply_low_flag(sup_low), .o_switch_on(sw),
      .o_sense_mode(smode), .o_sense_channel(s_chan),
      .o_sense_ratio(s_ratio), .o_fail_safe(fsafe),
      .o_serial_clear(sclr));

   // pin changes need two sync stages plus the register
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // one condition on output 1, then removal and a read
   task automatic run_ch1(input logic [4:0] c, input logic [5:0] s,
                          input logic o, input logic [2:0] e,
                          input logic ef);
      cfg[1] = c;
      sense[1] = s;
      cmd[1] = o;
      step(4);
      `CHK("flags1", e, flags[1])
      `CHK("flags0", 3'h0, flags[0])
      `CHK("fault_n", ef, fault_n)
      `CHK("switch1", o, sw[1])
      cfg[1] = '0;
      sense[1] = '0;
      cmd[1] = 1'b0;
      step(4);
      mcu_i.read_status();
      `CHK("flags1 clr", 3'h0, flags[1])
   endtask

   task automatic complete_run();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // main sequence: pin levels are gate,short,open,bulb,led,dir
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      sense = '0;
      supply = 5'h1c;
      cfg = '0;
      cmd = '0;
      duty = '0;
      ovl = '0;
      repeat (3) @(posedge clk);
      #1 rst_n = 1'b1;
      step(4);
      `CHK("fault_n rst", 1'b1, fault_n)
      sense[0] = 6'h30;
      step(4);
      `CHK("short flags", 3'h6, flags[0])
      `CHK("short pin", 1'b0, fault_n)
      mcu_i.read_status();
      `CHK("short kept", 3'h6, flags[0])
      sense[0] = '0;
      step(4);
      `CHK("pin back", 1'b1, fault_n)
      mcu_i.read_status();
      `CHK("short clr", 3'h0, flags[0])
      sense[0] = 6'h10;
      step(4);
      `CHK("gate high", 1'b0, flags[0].short_to_supply_flag)
      sense[0] = 6'h30;
      cmd[0] = 1'b1;
      step(4);
      `CHK("cmd on", 1'b0, flags[0].short_to_supply_flag)
      sense[0] = '0;
      cmd[0] = 1'b0;
      step(4);
      mcu_i.read_status();
      run_ch1(5'h00, 6'h28, 1'b0, 3'h2, 1'b0);
      run_ch1(5'h08, 6'h28, 1'b0, 3'h0, 1'b1);
      run_ch1(5'h10, 6'h30, 1'b0, 3'h0, 1'b1);
      run_ch1(5'h00, 6'h04, 1'b1, 3'h1, 1'b1);
      run_ch1(5'h02, 6'h04, 1'b1, 3'h0, 1'b1);
      run_ch1(5'h04, 6'h04, 1'b1, 3'h0, 1'b1);
      // led openload only shows at a period tick with full duty
      cfg[0] = 5'h02;
      duty[0] = 8'hfe;
      cmd[0] = 1'b1;
      sense[0] = 6'h02;
      mcu_i.hold_led(2 * LED_N + 4);
      `CHK("led part duty", 3'h0, flags[0])
      duty[0] = 8'hff;
      mcu_i.hold_led(2 * LED_N + 4);
      `CHK("led open", 3'h1, flags[0])
      `CHK("led sw", 1'b1, sw[0])
      `CHK("led pin", 1'b1, fault_n)
      sense[0] = '0;
      step(4);
      mcu_i.read_status();
      `CHK("led clr", 3'h0, flags[0])
      cmd[0] = 1'b0;
      cfg[0] = '0;
      // sense routing
      mcu_i.set_glb(6'h08);
      step(2);
      `CHK("temp route", SENSE_TEMP, smode)
      cfg[1] = 5'h01;
      cmd[1] = 1'b1;
      mcu_i.set_glb(6'h05);
      step(2);
      `CHK("cur route", SENSE_CURRENT, smode)
      `CHK("cur chan", 1'b1, s_chan)
      `CHK("cur ratio", 1'b1, s_ratio)
      cmd[1] = 1'b0;
      step(2);
      `CHK("sw off", SENSE_OFF, smode)
      // logic supply loss: fail-safe follows direct inputs
      cmd[1] = 1'b1;
      mcu_i.set_glb(6'h25);
      supply = 5'h0c;
      sense[0] = 6'h01;
      sense[1] = 6'h28;
      step(4);
      `CHK("fsafe", 1'b1, fsafe)
      `CHK("fs sw", 2'h1, sw)
      `CHK("fs sense", SENSE_OFF, smode)
      `CHK("fs clear", 1'b1, sclr)
      `CHK("fs open pin", 1'b0, fault_n)
      sense = '0;
      cmd = '0;
      supply = 5'h1c;
      mcu_i.set_glb(6'h00);
      step(4);
      mcu_i.read_status();
      // power loss with logic supply present
      supply = 5'h14;
      step(4);
      `CHK("uv flag", 1'b1, sup_low)
      `CHK("uv keep", 1'b0, sclr)
      `CHK("uv fsafe", 1'b0, fsafe)
      supply = 5'h1c;
      step(4);
      mcu_i.read_status();
      `CHK("uv clr", 1'b0, sup_low)
      // prewarning stays latched until read
      supply = 5'h1d;
      step(4);
      supply = 5'h1c;
      step(4);
      `CHK("prewarn", 1'b1, prewarn)
      mcu_i.read_status();
      `CHK("prewarn clr", 1'b0, prewarn)
      // clamp during overload turn-off switches both on
      ovl = 2'h1;
      supply = 5'h1e;
      step(4);
      `CHK("clamp sw", 2'h3, sw)
      ovl = '0;
      supply = 5'h1c;
      // both supplies gone clears latched faults
      sense[1] = 6'h30;
      step(4);
      supply = 5'h00;
      step(4);
      `CHK("por flags", 6'h00, flags)
      `CHK("por clear", 1'b1, sclr)
      complete_run();
   end

   // watchdog: the whole sequence needs well under 2000 cycles
   initial begin
      repeat (3000) @(posedge clk);
      fails++;
      complete_run();
   end
endmodule
